// ---- core/flash_cycle.sv ----
// one asynchronous bus cycle, read or write, on the flash pins
// assumes dq_sync already passed two flip-flops in the caller
`default_nettype none

module flash_cycle (
  // clock and reset
  input  wire logic                              ref_clk,
  input  wire logic                              rst,
  input  wire logic                              clk_en,
  // request
  input  wire logic                              start,
  input  wire flash_host_pkg::bus_step_t         step,
  input  wire logic [flash_host_pkg::DATA_W-1:0] dq_sync,
  // answer
  output logic                                   done,
  output logic [flash_host_pkg::DATA_W-1:0]      rdata,
  // pins
  output logic                                   ce_n,
  output logic                                   oe_n,
  output logic                                   we_n,
  output logic [flash_host_pkg::ADDR_W-1:0]      addr_o,
  output logic [flash_host_pkg::DATA_W-1:0]      dq_o,
  output logic                                   dq_oe
);

  typedef enum logic [1:0] {
    PH_IDLE   = 2'b00,
    PH_SETUP  = 2'b01,
    PH_STROBE = 2'b11,
    PH_HOLD   = 2'b10
  } phase_t;

  phase_t                           phase_reg;
  logic                             wr_reg;
  logic [flash_host_pkg::CNT_W-1:0] cnt_reg;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      phase_reg <= PH_IDLE;
      wr_reg    <= 1'b0;
      cnt_reg   <= '0;
      done      <= 1'b0;
      rdata     <= '0;
      ce_n      <= 1'b1;
      oe_n      <= 1'b1;
      we_n      <= 1'b1; // strobe high from power-up on
      addr_o    <= '0;
      dq_o      <= '0;
      dq_oe     <= 1'b0;
    end
    else if (clk_en)
    begin
      done <= 1'b0;
      case (phase_reg)
        PH_IDLE:
        begin
          if (start)
          begin
            // select first, output enable kept high for a write
            addr_o    <= step.addr;
            dq_o      <= step.data;
            dq_oe     <= step.wr;
            wr_reg    <= step.wr;
            ce_n      <= 1'b0;
            oe_n      <= 1'b1;
            cnt_reg   <= flash_host_pkg::SETUP_CYC;
            phase_reg <= PH_SETUP;
          end
        end
        PH_SETUP:
        begin
          if (cnt_reg <= 8'h01)
          begin
            // strobe falls after select, so the address is caught here
            we_n      <= ~wr_reg;
            oe_n      <= wr_reg;
            cnt_reg   <= wr_reg ? flash_host_pkg::WE_LOW_CYC
                                : flash_host_pkg::ACCESS_CYC;
            phase_reg <= PH_STROBE;
          end
          else
            cnt_reg <= cnt_reg - 8'h01;
        end
        PH_STROBE:
        begin
          if (cnt_reg <= 8'h01)
          begin
            // strobe rises before select, data caught on it
            we_n      <= 1'b1;
            oe_n      <= 1'b1;
            rdata     <= dq_sync;
            cnt_reg   <= flash_host_pkg::HOLD_CYC;
            phase_reg <= PH_HOLD;
          end
          else
            cnt_reg <= cnt_reg - 8'h01;
        end
        PH_HOLD:
        begin
          if (cnt_reg <= 8'h01)
          begin
            ce_n      <= 1'b1;
            dq_oe     <= 1'b0;
            done      <= 1'b1;
            phase_reg <= PH_IDLE;
          end
          else
            cnt_reg <= cnt_reg - 8'h01;
        end
        default:
          phase_reg <= PH_IDLE;
      endcase
    end
  end

  AST_ADDR_HELD: assert property (@(posedge ref_clk) disable iff (rst)
    !we_n |-> $stable(addr_o) && $stable(dq_o) && dq_oe)
    else $error("address or data moved while strobe low");

endmodule

`default_nettype wire

// ---- core/flash_host.sv ----
// host controller driving a parallel nor flash through its pins
// assumes the user holds cmd stable while cmd_valid is high
`default_nettype none

module flash_host (
  // clock and reset
  input  wire logic                              ref_clk,
  input  wire logic                              rst,
  input  wire logic                              clk_en,
  // user commands
  input  wire logic                              cmd_valid,
  input  wire flash_host_pkg::host_cmd_t         cmd,
  output logic                                   cmd_ready,
  input  wire logic                              byte_mode,
  input  wire logic                              unprotect_req,
  // user answers
  output logic                                   done,
  output logic [flash_host_pkg::DATA_W-1:0]      rdata,
  output logic                                   fail,
  output logic                                   cmd_error,
  output logic                                   bypass_active,
  output logic                                   device_busy,
  // flash pins
  output logic                                   flash_ce_n,
  output logic                                   flash_oe_n,
  output logic                                   flash_we_n,
  output logic [flash_host_pkg::ADDR_W-1:0]      flash_addr,
  output logic [flash_host_pkg::DATA_W-1:0]      flash_dq_o,
  output logic                                   flash_dq_oe,
  input  wire logic [flash_host_pkg::DATA_W-1:0] flash_dq_i,
  output logic                                   flash_reset_n,
  output logic                                   id_high_voltage,
  output logic                                   flash_byte_n,
  input  wire logic                              ready_busy_n
);

  typedef enum logic [2:0] {
    S_IDLE      = 3'b000,
    S_ISSUE     = 3'b001,
    S_WAIT      = 3'b011,
    S_POLL      = 3'b010,
    S_POLL_WAIT = 3'b110,
    S_HWRST     = 3'b111,
    S_RECOVER   = 3'b101
  } state_t;

  state_t                             state_reg;
  flash_host_pkg::host_cmd_t          cur_reg;
  flash_host_pkg::bus_step_t          step_next;
  flash_host_pkg::bus_step_t          cyc_step_reg;
  logic [2:0]                         idx_reg;
  logic [flash_host_pkg::CNT_W-1:0]   cnt_reg;
  logic                               recheck_reg;
  logic                               start_reg;
  logic                               cyc_done;
  logic [flash_host_pkg::DATA_W-1:0]  cyc_rdata;
  logic [flash_host_pkg::DATA_W-1:0]  dq_meta_reg;
  logic [flash_host_pkg::DATA_W-1:0]  dq_sync_reg;
  logic                               rb_meta_reg;
  logic                               rb_sync_reg;
  logic                               accept;
  logic                               op_ok;

  // pin inputs cross two flip-flops before any use
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      dq_meta_reg <= '0;
      dq_sync_reg <= '0;
      rb_meta_reg <= 1'b1;
      rb_sync_reg <= 1'b1;
      device_busy <= 1'b0;
    end
    else if (clk_en)
    begin
      dq_meta_reg <= flash_dq_i;
      dq_sync_reg <= dq_meta_reg;
      rb_meta_reg <= ready_busy_n;
      rb_sync_reg <= rb_meta_reg;
      device_busy <= ~rb_sync_reg; // progress seen on busy pin
    end
  end

  // sequence table: one bus step per index, invalid marks the end
  function automatic flash_host_pkg::bus_step_t step_at(
    input flash_host_pkg::op_t        op,
    input logic [2:0]                 idx,
    input logic [flash_host_pkg::ADDR_W-1:0] a,
    input logic [flash_host_pkg::DATA_W-1:0] d,
    input logic                       byte_n
  );
    logic [flash_host_pkg::ADDR_W-1:0] u1;
    logic [flash_host_pkg::ADDR_W-1:0] u2;
    flash_host_pkg::bus_step_t         s;
    u1 = byte_n ? flash_host_pkg::UNLOCK1_WORD_ADDR
                : flash_host_pkg::UNLOCK1_BYTE_ADDR;
    u2 = byte_n ? flash_host_pkg::UNLOCK2_WORD_ADDR
                : flash_host_pkg::UNLOCK2_BYTE_ADDR;
    s  = '{valid: 1'b0, wr: 1'b1, addr: a, data: d};
    if ((op == flash_host_pkg::OP_AUTOSEL || op == flash_host_pkg::OP_PROGRAM
        || op == flash_host_pkg::OP_BYP_ENTER) && idx < 3'd2)
      s = '{1'b1, 1'b1, (idx == 3'd0) ? u1 : u2,
            (idx == 3'd0) ? flash_host_pkg::UNLOCK1_DATA
                          : flash_host_pkg::UNLOCK2_DATA};
    else
      case (op)
        flash_host_pkg::OP_READ:
          s = '{idx == 3'd0, 1'b0, a, d}; // a read, never a write cycle
        flash_host_pkg::OP_RESET:
          s = '{idx == 3'd0, 1'b1, a, flash_host_pkg::RESET_CMD};
        flash_host_pkg::OP_AUTOSEL:
          case (idx)
            3'd2: s = '{1'b1, 1'b1, u1, flash_host_pkg::AUTOSEL_CMD};
            3'd3: s = '{1'b1, 1'b0, a, d};
            3'd4: s = '{1'b1, 1'b1, a, flash_host_pkg::RESET_CMD};
            default: s.valid = 1'b0;
          endcase
        flash_host_pkg::OP_PROGRAM:
          case (idx)
            3'd2: s = '{1'b1, 1'b1, u1, flash_host_pkg::PROG_SETUP_CMD};
            3'd3: s = '{1'b1, 1'b1, a, d};
            default: s.valid = 1'b0;
          endcase
        flash_host_pkg::OP_BYP_ENTER:
          s = '{idx == 3'd2, 1'b1, u1, flash_host_pkg::BYP_ENTER_CMD};
        flash_host_pkg::OP_BYP_PROG:
          s = '{idx < 3'd2, 1'b1, (idx == 3'd0) ? u1 : a,
                (idx == 3'd0) ? flash_host_pkg::BYP_PROG_CMD : d};
        flash_host_pkg::OP_BYP_EXIT:
          s = '{idx < 3'd2, 1'b1, a, (idx == 3'd0)
                ? flash_host_pkg::BYP_EXIT1_CMD
                : flash_host_pkg::BYP_EXIT2_CMD};
        default:
          s.valid = 1'b0;
      endcase
    return s;
  endfunction

  always_comb
  begin
    step_next = step_at(cur_reg.op, idx_reg, cur_reg.addr, cur_reg.data,
                        flash_byte_n);
    accept    = cmd_valid && cmd_ready;
    // bypass mode takes only its own program and exit, and hardware reset
    if (bypass_active)
      op_ok = cmd.op == flash_host_pkg::OP_BYP_PROG ||
              cmd.op == flash_host_pkg::OP_BYP_EXIT ||
              cmd.op == flash_host_pkg::OP_HW_RESET;
    else
      op_ok = cmd.op != flash_host_pkg::OP_BYP_PROG &&
              cmd.op != flash_host_pkg::OP_BYP_EXIT;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      // every reset starts with a hardware reset pulse
      state_reg       <= S_HWRST;
      cur_reg         <= '0;
      cyc_step_reg    <= '0;
      idx_reg         <= '0;
      cnt_reg         <= flash_host_pkg::RESET_PULSE_CYC;
      recheck_reg     <= 1'b0;
      start_reg       <= 1'b0;
      cmd_ready       <= 1'b0;
      done            <= 1'b0;
      rdata           <= '0;
      fail            <= 1'b0;
      cmd_error       <= 1'b0;
      bypass_active   <= 1'b0;
      flash_reset_n   <= 1'b0;
      id_high_voltage <= 1'b0;
      flash_byte_n    <= 1'b1;
    end
    else if (clk_en)
    begin
      done      <= 1'b0;
      cmd_error <= 1'b0;
      start_reg <= 1'b0;
      case (state_reg)
        S_IDLE:
        begin
          cmd_ready <= 1'b1;
          // pin voltage only changes between commands; no unprotect
          // write cycle is ever issued, so nothing needs protecting first
          id_high_voltage <= unprotect_req;
          if (accept)
          begin
            if (!op_ok)
            begin
              cmd_error <= 1'b1;
              done      <= 1'b1;
            end
            else
            begin
              cmd_ready    <= 1'b0;
              cur_reg      <= cmd;
              idx_reg      <= '0;
              fail         <= 1'b0;
              recheck_reg  <= 1'b0;
              flash_byte_n <= ~byte_mode; // byte pin sets width
              if (cmd.op == flash_host_pkg::OP_HW_RESET)
              begin
                flash_reset_n <= 1'b0;
                cnt_reg       <= flash_host_pkg::RESET_PULSE_CYC;
                state_reg     <= S_HWRST;
              end
              else
                state_reg <= S_ISSUE;
            end
          end
        end
        S_ISSUE:
        begin
          if (step_next.valid)
          begin
            start_reg    <= 1'b1;
            cyc_step_reg <= step_next;
            state_reg    <= S_WAIT;
          end
          else if (cur_reg.op == flash_host_pkg::OP_PROGRAM ||
                   cur_reg.op == flash_host_pkg::OP_BYP_PROG)
            state_reg <= S_POLL;
          else
          begin
            if (cur_reg.op == flash_host_pkg::OP_BYP_ENTER)
              bypass_active <= 1'b1;
            else if (cur_reg.op == flash_host_pkg::OP_BYP_EXIT ||
                     cur_reg.op == flash_host_pkg::OP_RESET)
              bypass_active <= 1'b0;
            done      <= 1'b1;
            state_reg <= S_IDLE;
          end
        end
        S_WAIT:
        begin
          if (cyc_done)
          begin
            if (!cyc_step_reg.wr)
              rdata <= cyc_rdata;
            idx_reg   <= idx_reg + 3'd1;
            state_reg <= S_ISSUE;
          end
        end
        S_POLL:
        begin
          // only reads while the algorithm runs; writes would be ignored
          start_reg    <= 1'b1;
          cyc_step_reg <= '{1'b1, 1'b0, cur_reg.addr, cur_reg.data};
          state_reg    <= S_POLL_WAIT;
        end
        S_POLL_WAIT:
        begin
          if (cyc_done)
          begin
            rdata <= cyc_rdata;
            if (cyc_rdata[flash_host_pkg::POLL_BIT] ==
                cur_reg.data[flash_host_pkg::POLL_BIT])
            begin
              done      <= 1'b1; // device back in read-array
              state_reg <= S_IDLE;
            end
            else if (cyc_rdata[flash_host_pkg::LIMIT_BIT] && recheck_reg)
            begin
              // time limit hit, often a 0 to 1 attempt; reset restores
              // array reads
              fail         <= 1'b1;
              cur_reg.op   <= flash_host_pkg::OP_RESET;
              idx_reg      <= '0;
              state_reg    <= S_ISSUE;
            end
            else
            begin
              // the poll bit may settle after the limit bit: read once more
              recheck_reg <= cyc_rdata[flash_host_pkg::LIMIT_BIT];
              state_reg   <= S_POLL;
            end
          end
        end
        S_HWRST:
        begin
          if (cnt_reg <= 8'h01)
          begin
            flash_reset_n <= 1'b1;
            cnt_reg       <= flash_host_pkg::RESET_RECOVER_CYC;
            state_reg     <= S_RECOVER;
          end
          else
            cnt_reg <= cnt_reg - 8'h01;
        end
        S_RECOVER:
        begin
          if (cnt_reg <= 8'h01)
          begin
            bypass_active <= 1'b0;
            done      <= (cur_reg.op == flash_host_pkg::OP_HW_RESET);
            state_reg <= S_IDLE;
          end
          else
            cnt_reg <= cnt_reg - 8'h01;
        end
        default:
          state_reg <= S_IDLE;
      endcase
    end
  end

  flash_cycle u_cycle (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clk_en  (clk_en),
    .start   (start_reg),
    .step    (cyc_step_reg),
    .dq_sync (dq_sync_reg),
    .done    (cyc_done),
    .rdata   (cyc_rdata),
    .ce_n    (flash_ce_n),
    .oe_n    (flash_oe_n),
    .we_n    (flash_we_n),
    .addr_o  (flash_addr),
    .dq_o    (flash_dq_o),
    .dq_oe   (flash_dq_oe)
  );

  AST_WRITE_QUAL: assert property (@(posedge ref_clk) disable iff (rst)
    !flash_we_n |-> !flash_ce_n && flash_oe_n && flash_reset_n)
    else $error("write strobe low without qualified bus");

  AST_PWRUP_WE: assert property (@(posedge ref_clk)
    rst |=> flash_we_n && !flash_reset_n)
    else $error("strobe or reset pin wrong after reset");

  AST_BYP_REJECT: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && state_reg == S_IDLE && accept && bypass_active &&
    cmd.op == flash_host_pkg::OP_PROGRAM |=> cmd_error && done && cmd_ready)
    else $error("plain program accepted in bypass mode");

  AST_HWRST_PIN: assert property (@(posedge ref_clk) disable iff (rst)
    state_reg == S_HWRST |-> !flash_reset_n && flash_ce_n && flash_we_n)
    else $error("reset pin released during reset pulse");

  AST_VID_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && state_reg != S_IDLE |=> $stable(id_high_voltage))
    else $error("id voltage changed during a command");

  AST_POLL_NOWRITE: assert property (@(posedge ref_clk) disable iff (rst)
    state_reg == S_POLL_WAIT |-> flash_we_n)
    else $error("write issued while program runs");

  AST_PROG_POLLS: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(state_reg == S_POLL) |-> idx_reg == 3'd4 ||
    (cur_reg.op == flash_host_pkg::OP_BYP_PROG && idx_reg == 3'd2) ||
    $past(state_reg) == S_POLL_WAIT)
    else $error("polling began before all program writes");

  AST_FAIL_RESET: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && state_reg == S_POLL_WAIT && cyc_done && recheck_reg &&
    cyc_rdata[5] && cyc_rdata[7] != cur_reg.data[7]
    |=> fail && cur_reg.op == flash_host_pkg::OP_RESET && state_reg == S_ISSUE)
    else $error("time limit did not lead to reset command");

endmodule

`default_nettype wire

// ---- core/flash_host_pkg.sv ----
// constants, command codes and carrier types for the flash host controller
// assumes a 250 MHz ref_clk and an asynchronous parallel nor flash on pins
//
// Contract
// - host protects all before unprotect write cycles; this host issues none, it only drives id_high_voltage between commands
// - write only with select, strobe low, output-enable high
// - time limit flag high needs reset command
// - program is four writes, byte pin sets width
`default_nettype none

package flash_host_pkg;

  localparam int ADDR_W = 19;
  localparam int DATA_W = 16;
  localparam int CNT_W  = 8;

  // bus timing, least times rounded up to whole cycles
  localparam int CLK_PERIOD_NS   = 4;
  localparam int SETUP_NS        = 20;
  localparam int WE_LOW_NS       = 35;
  localparam int ACCESS_NS       = 55;
  localparam int HOLD_NS         = 20;
  localparam int RESET_PULSE_NS  = 500;
  localparam int RESET_RECOVER_NS = 50;
  localparam int SYNC_STAGES     = 2;

  localparam logic [CNT_W-1:0] SETUP_CYC =
    CNT_W'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] WE_LOW_CYC =
    CNT_W'((WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] ACCESS_CYC =
    CNT_W'((ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES);
  localparam logic [CNT_W-1:0] HOLD_CYC =
    CNT_W'((HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RESET_PULSE_CYC =
    CNT_W'((RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RESET_RECOVER_CYC =
    CNT_W'((RESET_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // command cycle addresses and data
  localparam logic [ADDR_W-1:0] UNLOCK1_WORD_ADDR = 19'h0_0555;
  localparam logic [ADDR_W-1:0] UNLOCK2_WORD_ADDR = 19'h0_02AA;
  localparam logic [ADDR_W-1:0] UNLOCK1_BYTE_ADDR = 19'h0_0AAA;
  localparam logic [ADDR_W-1:0] UNLOCK2_BYTE_ADDR = 19'h0_0555;
  localparam logic [DATA_W-1:0] UNLOCK1_DATA      = 16'h00AA;
  localparam logic [DATA_W-1:0] UNLOCK2_DATA      = 16'h0055;
  localparam logic [DATA_W-1:0] RESET_CMD         = 16'h00F0;
  localparam logic [DATA_W-1:0] AUTOSEL_CMD       = 16'h0090;
  localparam logic [DATA_W-1:0] PROG_SETUP_CMD    = 16'h00A0;
  localparam logic [DATA_W-1:0] BYP_ENTER_CMD     = 16'h0020;
  localparam logic [DATA_W-1:0] BYP_PROG_CMD      = 16'h00A0;
  localparam logic [DATA_W-1:0] BYP_EXIT1_CMD     = 16'h0090;
  localparam logic [DATA_W-1:0] BYP_EXIT2_CMD     = 16'h0000;

  // status bit positions in read data
  localparam int POLL_BIT  = 7;
  localparam int LIMIT_BIT = 5;

  typedef enum logic [2:0] {
    OP_READ      = 3'h0,
    OP_RESET     = 3'h1,
    OP_AUTOSEL   = 3'h2,
    OP_PROGRAM   = 3'h3,
    OP_BYP_ENTER = 3'h4,
    OP_BYP_PROG  = 3'h5,
    OP_BYP_EXIT  = 3'h6,
    OP_HW_RESET  = 3'h7
  } op_t;

  typedef struct packed {
    op_t               op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } host_cmd_t;

  typedef struct packed {
    logic              valid;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } bus_step_t;

endpackage

`default_nettype wire

// ---- tb/flash_host_bench.sv ----
// self-checking bench: flash_host driving the behavioural flash model
// assumes word mode and sector 7 factory-protected in the model
`default_nettype none

module flash_host_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        cmd_valid = 1'b0;
  logic        unprotect_req = 1'b0;
  logic        done, cmd_ready, fail, cmd_error, bypass_active, err;
  logic        ce_n, oe_n, we_n, dq_oe, reset_n, id_high_voltage;
  logic        ready_busy_n;
  logic        byte_mode = 1'b0, byte_n, dev_busy;
  logic [18:0] addr;
  logic [15:0] rdata, dq_o, dev_dq, dq_bus;
  int          mismatches = 0, check_count = 0, cyc = 0;
  flash_host_pkg::host_cmd_t cmd = '0;

  always #2 ref_clk = ~ref_clk;
  assign dq_bus = dq_oe ? dq_o : dev_dq;

  flash_host dut (.ref_clk, .rst, .clk_en(1'b1), .cmd_valid, .cmd,
    .cmd_ready, .byte_mode, .unprotect_req, .done, .rdata, .fail,
    .cmd_error, .bypass_active, .device_busy(dev_busy), .flash_ce_n(ce_n),
    .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_addr(addr),
    .flash_dq_o(dq_o), .flash_dq_oe(dq_oe), .flash_dq_i(dq_bus),
    .flash_reset_n(reset_n), .id_high_voltage, .flash_byte_n(byte_n),
    .ready_busy_n);
  flash_model #(.PROT_INIT(8'h80)) model (.ce_n, .oe_n, .we_n, .reset_n,
    .id_high_voltage, .addr, .dq_in(dq_bus), .dq_out(dev_dq), .ready_busy_n);

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // op codes: 0 read 1 reset 2 autosel 3 program 4-6 bypass 7 hw reset
  task automatic run(input logic [2:0] op, input logic [18:0] a,
                     input logic [15:0] d);
    @(negedge ref_clk);
    cmd_valid = 1'b1;
    cmd = '{flash_host_pkg::op_t'(op), a, d};
    while (cmd_ready !== 1'b1) @(negedge ref_clk);
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    while (done !== 1'b1) @(negedge ref_clk);
    err = cmd_error;
  endtask

  task automatic rc(input logic [2:0] op, input logic [18:0] a,
                    input logic [15:0] exp);
    run(op, a, 16'h0000);
    check(rdata, exp);
  endtask

  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      mismatches++;
      report_and_stop();
    end
  end

  initial
  begin
    repeat (20) @(negedge ref_clk);
    rst = 1'b0;
    rc(3'h0, 19'h0_0010, 16'hFFFF);
    run(3'h3, 19'h0_0010, 16'h1234);
    rc(3'h0, 19'h0_0010, 16'h1234);
    check(16'(dev_busy), 16'h0000);
    check(16'(byte_n), 16'h0001);
    run(3'h3, 19'h0_0010, 16'hFFFF);
    check(16'(fail), 16'h0001);
    rc(3'h0, 19'h0_0010, 16'h1234);
    rc(3'h2, 19'h0_0000, model.MAKER_ID);
    rc(3'h2, 19'h0_0001, model.DEVICE_ID);
    rc(3'h2, 19'h3_8002, 16'h0001);
    rc(3'h2, 19'h0_0002, 16'h0000);
    run(3'h1, 19'h5_5555, 16'h0000);
    rc(3'h0, 19'h0_0010, 16'h1234);
    run(3'h3, 19'h3_8030, 16'h00AA);
    rc(3'h0, 19'h3_8030, 16'hFFFF);
    unprotect_req = 1'b1;
    run(3'h3, 19'h3_8030, 16'h00AA);
    unprotect_req = 1'b0;
    rc(3'h0, 19'h3_8030, 16'h00AA);
    rc(3'h2, 19'h3_8002, 16'h0001);
    run(3'h3, 19'h3_8030, 16'h0080);
    rc(3'h0, 19'h3_8030, 16'h00AA);
    byte_mode = 1'b1;
    run(3'h1, '0, 16'h0000);
    check(16'(byte_n), 16'h0000);
    byte_mode = 1'b0;
    run(3'h4, '0, 16'h0000);
    check(16'(bypass_active), 16'h0001);
    run(3'h3, '0, 16'h0080);
    check(16'(err), 16'h0001);
    run(3'h5, 19'h0_0020, 16'h5A5A);
    run(3'h5, 19'h0_0021, 16'h00C3);
    run(3'h6, '0, 16'h0000);
    check(16'(bypass_active), 16'h0000);
    rc(3'h0, 19'h0_0020, 16'h5A5A);
    rc(3'h0, 19'h0_0021, 16'h00C3);
    run(3'h7, '0, 16'h0000);
    rc(3'h0, 19'h0_0010, 16'h1234);
    report_and_stop();
  end
endmodule

`default_nettype wire

// ---- tb/flash_model.sv ----
// behavioural nor flash device on the host pins, word mode only
// assumes a bench-resolved data bus; address aliases to 256 words
`default_nettype none

module flash_model #(
  parameter logic [15:0] MAKER_ID  = 16'h005A, // arbitrary value
  parameter logic [15:0] DEVICE_ID = 16'h00C5, // arbitrary value
  parameter logic [7:0]  PROT_INIT = 8'h00
) (
  // host pins
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        reset_n,
  input  wire logic        id_high_voltage,
  input  wire logic [18:0] addr,
  input  wire logic [15:0] dq_in,
  // device answers
  output logic      [15:0] dq_out,
  output logic             ready_busy_n
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [15:0] mem [0:255];
  logic [7:0]  prot = PROT_INIT;
  logic [18:0] a_lat;
  logic [18:0] pa;
  logic [15:0] pd;
  logic [15:0] v;
  logic [15:0] last;
  logic [2:0]  st   = 3'h0;
  logic        busy = 1'b0;
  logic        lim  = 1'b0;
  logic        tog  = 1'b0;
  logic        armed = 1'b0;

  initial foreach (mem[i]) mem[i] = 16'hFFFF;
  assign ready_busy_n = ~busy;
  always @(negedge oe_n) tog = ~tog;
  always @(negedge reset_n) {st, busy, lim} = 5'h00;
  // strobes already low at power-up never arm the latch
  always @(negedge we_n or negedge ce_n)
    if (!we_n && !ce_n) {a_lat, armed} = {addr, 1'b1};
  // data taken when the first of the two strobes rises
  always @(posedge we_n or posedge ce_n)
    if ((we_n ^ ce_n) && oe_n && reset_n && armed)
      wr(a_lat, dq_in);

  task automatic prog(input logic [18:0] a, input logic [15:0] d);
    st = (st == 3'h6) ? 3'h5 : 3'h0;
    if (!prot[a[17:15]] || id_high_voltage)
    begin
      pa = a;
      pd = d;
      lim = |(d & ~mem[a[7:0]]);
      busy = 1'b1;
    end
  endtask

  task automatic wr(input logic [18:0] a, input logic [15:0] d);
    armed = 1'b0;
    if (busy)
    begin
      if (lim && d == flash_host_pkg::RESET_CMD) {st, busy, lim} = 5'h00;
    end
    else if (d == flash_host_pkg::RESET_CMD && st != 3'h5 && st != 3'h7)
      st = 3'h0;
    else
      case (st)
        3'h0: st = (a == flash_host_pkg::UNLOCK1_WORD_ADDR
                 && d == flash_host_pkg::UNLOCK1_DATA) ? 3'h1 : 3'h0;
        3'h1: st = (a == flash_host_pkg::UNLOCK2_WORD_ADDR
                 && d == flash_host_pkg::UNLOCK2_DATA) ? 3'h2 : 3'h0;
        3'h2: st = a != flash_host_pkg::UNLOCK1_WORD_ADDR ? 3'h0
                 : d == flash_host_pkg::AUTOSEL_CMD ? 3'h3
                 : d == flash_host_pkg::PROG_SETUP_CMD ? 3'h4
                 : d == flash_host_pkg::BYP_ENTER_CMD ? 3'h5 : 3'h0;
        3'h4, 3'h6: prog(a, d);
        3'h5: st = d == flash_host_pkg::BYP_PROG_CMD ? 3'h6
                 : d == flash_host_pkg::BYP_EXIT1_CMD ? 3'h7 : 3'h5;
        3'h7: st = d == flash_host_pkg::BYP_EXIT2_CMD ? 3'h0 : 3'h5;
        default: st = st; // autoselect waits for reset
      endcase
  endtask

  // a failed program never ends: only a reset write or the reset pin clears it
  always @(posedge busy)
  begin
    #400;
    if (!lim) {mem[pa[7:0]], busy} = {mem[pa[7:0]] & pd, 1'b0};
  end

  always @*
  begin
    if (busy) v = {8'h00, ~pd[7], tog, lim, 5'h00};
    else if (st == 3'h3) v = addr[1:0] == 2'h0 ? MAKER_ID
      : addr[1:0] == 2'h1 ? DEVICE_ID : {15'h0000, prot[addr[17:15]]};
    else v = mem[addr[7:0]];
    if (reset_n && !ce_n && !oe_n) last = v;
    dq_out = (reset_n && !ce_n && !oe_n) ? v : ~last;
  end
endmodule

`default_nettype wire
